/* hdl/rsq_consts.svh */
// Register map, field positions, reset values and timing constants of the reset sequencer
`ifndef RSQ_CONSTS_SVH
`define RSQ_CONSTS_SVH

// Word-aligned byte offsets
`define RSQ_MISC_OFS      8'h00
`define RSQ_PROBE_OFS     8'h04
`define RSQ_STR_OFS       8'h08
`define RSQ_CSC_OFS       8'h0c
`define RSQ_TTR_OFS       8'h10
`define RSQ_TDR_OFS       8'h14
`define RSQ_MTR_OFS       8'h18
`define RSQ_AAR0_OFS      8'h1c
`define RSQ_PWR_OFS       8'h2c
`define RSQ_PCICTL_OFS    8'h30
`define RSQ_STRAP_OFS     8'h34

// Misc control fields
`define RSQ_CPU_NUMBER_FIELD_BIT     0
`define RSQ_TRY_LSB       4
`define RSQ_WON_LSB       8
`define RSQ_ARB_CLR_BIT   12
// Power, PCI control and memory timing fields, and the array address register count
`define RSQ_SR_BIT        0
`define RSQ_ARB_EN_BIT    0
`define RSQ_RI_LSB        0
`define RSQ_RI_SHIFT      4
`define RSQ_AAR_COUNT     4

// Reset values
`define RSQ_REG_RST       32'h0000_0000
`define RSQ_PROBE_RST     2'h0

// Timing
`define RSQ_CLK_MHZ       50
`define RSQ_PCI_HALF      4'h1
`define RSQ_PCI_RST_DLY   4'h4
`endif

/* hdl/rsq_pkg.sv */
// Types shared by the reset and power sequencer
package rsq_pkg;
  // SDRAM command codes
  typedef enum logic [1:0] {
    RSQ_CMD_NOP  = 2'b00,
    RSQ_CMD_PRE  = 2'b01,
    RSQ_CMD_REF  = 2'b10,
    RSQ_CMD_SELF = 2'b11
  } rsq_cmd_e;

  // Command with the array it addresses
  typedef struct packed {
    rsq_cmd_e   cmd;
    logic [1:0] array;
  } rsq_sdram_cmd_s;

  // Memory controller states
  typedef enum logic [1:0] {
    RSQ_ST_PRECHG = 2'b00,
    RSQ_ST_RUN    = 2'b01,
    RSQ_ST_SRENT  = 2'b10,
    RSQ_ST_SRHOLD = 2'b11
  } rsq_mem_e;
endpackage

/* hdl/rsq_pci_reset.sv */
// PCI clock divider and reset output sequencing
`timescale 1ns/1ns
`include "rsq_consts.svh"
module rsq_pci_reset import rsq_pkg::*; (
  // Clock and reset
  input  wire logic clk_i,
  input  wire logic rst_i,
  // PCI side
  output logic      pci_clk_o,
  output logic      pci_rst_n_o,
  output logic      wide_req_n_o,
  output logic      wide_req_oe_o
);
  logic [3:0] div;
  logic [3:0] dly;
  logic       tick;
  logic       drove_high;

  // Rising edge of the PCI clock comes on the next toggle from low
  assign tick = (div == `RSQ_PCI_HALF) && !pci_clk_o;

  // Divider for the PCI output clock
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      div       <= 4'h0;
      pci_clk_o <= 1'b0;
    end else if (div == `RSQ_PCI_HALF) begin
      div       <= 4'h0;
      pci_clk_o <= !pci_clk_o;
    end else begin
      div <= div + 4'h1;
    end
  end

  // Reset asserts with the system reset, releases on a PCI edge
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pci_rst_n_o <= 1'b0;
      dly         <= 4'h0;
    end else if (tick && !pci_rst_n_o) begin
      if (dly == `RSQ_PCI_RST_DLY) begin
        pci_rst_n_o <= 1'b1;
      end else begin
        dly <= dly + 4'h1;
      end
    end
  end

  // Wide request low during reset, high one PCI cycle, then released
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wide_req_n_o  <= 1'b0;
      wide_req_oe_o <= 1'b1;
      drove_high    <= 1'b0;
    end else if (tick && pci_rst_n_o) begin
      if (!drove_high) begin
        wide_req_n_o <= 1'b1;
        drove_high   <= 1'b1;
      end else begin
        wide_req_oe_o <= 1'b0;
      end
    end
  end

  // Wide request driven low for every cycle that PCI reset is low
  wide_held_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !pci_rst_n_o |-> (wide_req_oe_o && !wide_req_n_o)) else $error("wide request not held in reset");
  // Release only on a PCI rising edge
  rst_on_edge_a: assert property (@(posedge clk_i) disable iff (rst_i)
    $rose(pci_rst_n_o) |-> $past(tick)) else $error("PCI reset released off edge");
  // After release: one PCI cycle low, one high, then tristate
  wide_release_a: assert property (@(posedge clk_i) disable iff (rst_i)
    $rose(pci_rst_n_o) |-> !wide_req_n_o ##4 wide_req_n_o && wide_req_oe_o ##4 !wide_req_oe_o)
    else $error("wide request release order wrong");
endmodule

/* hdl/rsq_top.sv */
// Reset, bring-up and self-refresh sequencer with Wishbone register slave
// Contract
// - After reset only register access works; CPU probes stay off until enabled.
// - System reset asserts PCI reset at once and drives wide request low.
// - PCI reset releases synchronously to the PCI clock, cycles after reset.
// - One PCI cycle after release drive wide request high once, then release.
// - Internal PCI arbiter stays disabled after reset; grants pulled high.
// - Weak pull-ups on requests, grant, AD, parity and byte enables.
// - Setting self-refresh bit sends self-refresh to each array, holds clock enables low.
// - During reset clock enables high, no commands; precharge all after release.
// - Clearing self-refresh raises clock enables; refresh resumes one interval later.
// - Configuration strap captured at reset release; bits 1:0 give base config.
`timescale 1ns/1ns
`include "rsq_consts.svh"
module rsq_top import rsq_pkg::*; #(
  parameter int ARRAYS = `RSQ_AAR_COUNT
) (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Wishbone slave
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [7:0]  adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic [31:0]      dat_o,
  output logic             ack_o,
  // Requesting CPU number and configuration strap
  input  wire logic        req_cpu_i,
  input  wire logic [7:0]  cfg_strap_i,
  // CPU probes and PCI arbiter
  output logic [1:0]       probe_en_o,
  output logic             pci_gnt_oe_o,
  output logic             pullup_en_o,
  // PCI reset pins
  output logic             pci_clk_o,
  output logic             pci_rst_n_o,
  output logic             wide_req_n_o,
  output logic             wide_req_oe_o,
  // SDRAM
  output rsq_sdram_cmd_s   sdram_cmd_o,
  output logic [3:0]       sdram_cke_o
);
  logic [1:0]  arb_try;
  logic [1:0]  arb_won;
  logic [31:0] sys_timing;
  logic [31:0] sys_config;
  logic [31:0] slow_timing;
  logic [31:0] slow_dev_timing;
  logic [31:0] mem_timing;
  logic [31:0] array_addr [ARRAYS];
  logic        self_refresh;
  logic        arb_enable;
  logic [7:0]  strap;
  logic        rst_q;
  logic        wr;
  logic        rd_go;
  logic [31:0] next_rdata;
  rsq_mem_e    mem_st;
  logic [1:0]  arr_idx;
  logic [11:0] ref_cnt;
  logic [11:0] ref_ivl;

  // Byte-lane merge used by the timing, config and array address registers
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d, input logic [3:0] s);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (s[i]) begin
        r[i*8 +: 8] = d[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // Write takes effect on the edge the master sees ack
  assign wr      = cyc_i && stb_i && we_i && ack_o;
  assign rd_go   = cyc_i && stb_i && !ack_o;
  assign ref_ivl = {mem_timing[`RSQ_RI_LSB +: 8], 4'h0};

  // Single-cycle registered ack; unmapped addresses ack too
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
      dat_o <= `RSQ_REG_RST;
    end else begin
      ack_o <= rd_go;
      if (rd_go) begin
        dat_o <= next_rdata;
      end
    end
  end

  // Read mux; only register access is meaningful after reset
  always_comb begin
    next_rdata = 32'h0000_0000;
    case (adr_i)
      `RSQ_MISC_OFS: begin
        next_rdata[`RSQ_CPU_NUMBER_FIELD_BIT]      = req_cpu_i;
        next_rdata[`RSQ_TRY_LSB +: 2]   = arb_try;
        next_rdata[`RSQ_WON_LSB +: 2]   = arb_won;
      end
      `RSQ_PROBE_OFS:  next_rdata[1:0] = probe_en_o;
      `RSQ_STR_OFS:    next_rdata = sys_timing;
      `RSQ_CSC_OFS:    next_rdata = sys_config;
      `RSQ_TTR_OFS:    next_rdata = slow_timing;
      `RSQ_TDR_OFS:    next_rdata = slow_dev_timing;
      `RSQ_MTR_OFS:    next_rdata = mem_timing;
      `RSQ_PWR_OFS:    next_rdata[`RSQ_SR_BIT] = self_refresh;
      `RSQ_PCICTL_OFS: next_rdata[`RSQ_ARB_EN_BIT] = arb_enable;
      `RSQ_STRAP_OFS:  next_rdata[7:0] = strap;
      default: begin
        for (int i = 0; i < ARRAYS; i++) begin
          if (adr_i == `RSQ_AAR0_OFS + 8'(i * 4)) begin
            next_rdata = array_addr[i];
          end
        end
      end
    endcase
  end

  // Arbitration: try sets freely, won only for the first CPU to claim while won is clear
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      arb_try <= 2'h0;
      arb_won <= 2'h0;
    end else if (wr && adr_i == `RSQ_MISC_OFS && sel_i[1]) begin
      if (dat_i[`RSQ_ARB_CLR_BIT]) begin
        arb_try <= 2'h0;
        arb_won <= 2'h0;
      end else begin
        arb_try <= arb_try | dat_i[`RSQ_TRY_LSB +: 2];
        if (arb_won == 2'h0) begin
          arb_won <= dat_i[`RSQ_WON_LSB +: 2] & (dat_i[`RSQ_WON_LSB] ? 2'b01 : 2'b10);
        end
      end
    end
  end

  // Plain configuration registers; ordering is left to firmware
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sys_timing      <= `RSQ_REG_RST;
      sys_config      <= `RSQ_REG_RST;
      slow_timing     <= `RSQ_REG_RST;
      slow_dev_timing <= `RSQ_REG_RST;
      mem_timing      <= `RSQ_REG_RST;
      probe_en_o      <= `RSQ_PROBE_RST;
      arb_enable      <= 1'b0;
    end else if (wr) begin
      case (adr_i)
        `RSQ_STR_OFS:    sys_timing      <= merge(sys_timing, dat_i, sel_i);
        `RSQ_CSC_OFS:    sys_config      <= merge(sys_config, dat_i, sel_i);
        `RSQ_TTR_OFS:    slow_timing     <= merge(slow_timing, dat_i, sel_i);
        `RSQ_TDR_OFS:    slow_dev_timing <= merge(slow_dev_timing, dat_i, sel_i);
        `RSQ_MTR_OFS:    mem_timing      <= merge(mem_timing, dat_i, sel_i);
        `RSQ_PROBE_OFS:  if (sel_i[0]) probe_en_o <= dat_i[1:0];
        `RSQ_PCICTL_OFS: if (sel_i[0]) arb_enable <= dat_i[`RSQ_ARB_EN_BIT];
        default: ;
      endcase
    end
  end

  // Array address registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int i = 0; i < ARRAYS; i++) begin
        array_addr[i] <= `RSQ_REG_RST;
      end
    end else if (wr) begin
      for (int i = 0; i < ARRAYS; i++) begin
        if (adr_i == `RSQ_AAR0_OFS + 8'(i * 4)) begin
          array_addr[i] <= merge(array_addr[i], dat_i, sel_i);
        end
      end
    end
  end

  // Self-refresh control bit
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      self_refresh <= 1'b0;
    end else if (wr && adr_i == `RSQ_PWR_OFS && sel_i[0]) begin
      self_refresh <= dat_i[`RSQ_SR_BIT];
    end
  end

  // Strap caught on the edge after reset release
  always_ff @(posedge clk_i) begin
    rst_q <= rst_i;
    if (rst_q && !rst_i) begin
      strap <= cfg_strap_i;
    end
  end

  // Grants driven only with arbiter on; pull-ups always on
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pci_gnt_oe_o <= 1'b0;
      pullup_en_o  <= 1'b1;
    end else begin
      pci_gnt_oe_o <= arb_enable;
      pullup_en_o  <= 1'b1;
    end
  end

  // SDRAM sequencing: precharge after reset, refresh, self-refresh entry and exit
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mem_st      <= RSQ_ST_PRECHG;
      sdram_cmd_o <= '{cmd: RSQ_CMD_NOP, array: 2'h0};
      sdram_cke_o <= 4'hf;
      arr_idx     <= 2'h0;
      ref_cnt     <= 12'h000;
    end else begin
      sdram_cmd_o <= '{cmd: RSQ_CMD_NOP, array: 2'h0};
      case (mem_st)
        RSQ_ST_PRECHG: begin
          sdram_cmd_o <= '{cmd: RSQ_CMD_PRE, array: arr_idx};
          arr_idx     <= arr_idx + 2'h1;
          if (arr_idx == 2'(ARRAYS - 1)) begin
            arr_idx <= 2'h0;
            mem_st  <= RSQ_ST_RUN;
          end
        end
        RSQ_ST_RUN: begin
          if (self_refresh) begin
            mem_st <= RSQ_ST_SRENT;
          end else if (ref_ivl != 12'h000) begin
            if (ref_cnt >= ref_ivl) begin
              ref_cnt     <= 12'h000;
              sdram_cmd_o <= '{cmd: RSQ_CMD_REF, array: 2'h0};
            end else begin
              ref_cnt <= ref_cnt + 12'h001;
            end
          end
        end
        RSQ_ST_SRENT: begin
          sdram_cmd_o          <= '{cmd: RSQ_CMD_SELF, array: arr_idx};
          sdram_cke_o[arr_idx] <= 1'b0;
          arr_idx              <= arr_idx + 2'h1;
          if (arr_idx == 2'(ARRAYS - 1)) begin
            arr_idx <= 2'h0;
            mem_st  <= RSQ_ST_SRHOLD;
          end
        end
        RSQ_ST_SRHOLD: begin
          // Leaving restarts the interval so refresh waits a full period
          if (!self_refresh) begin
            sdram_cke_o <= 4'hf;
            ref_cnt     <= 12'h000;
            mem_st      <= RSQ_ST_RUN;
          end
        end
        default: mem_st <= RSQ_ST_RUN;
      endcase
    end
  end

  // PCI reset and wide-request sequencing
  rsq_pci_reset rsq_pci_reset_i (
    .clk_i         (clk_i),
    .rst_i         (rst_i),
    .pci_clk_o     (pci_clk_o),
    .pci_rst_n_o   (pci_rst_n_o),
    .wide_req_n_o  (wide_req_n_o),
    .wide_req_oe_o (wide_req_oe_o)
  );

  // Probes off on the first cycle after reset, before any write
  probes_off_a: assert property (@(posedge clk_i) disable iff (rst_i)
    $past(rst_i) |-> probe_en_o == 2'h0) else $error("probes on after reset");
  // At most one won bit ever set
  won_single_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !(arb_won[0] && arb_won[1])) else $error("two CPUs won");
  // Grants not driven until arbiter enabled
  arb_off_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !arb_enable |=> !pci_gnt_oe_o) else $error("grant driven while arbiter off");
  // Precharge issued on the first edge after release
  precharge_first_a: assert property (@(posedge clk_i)
    $fell(rst_i) |=> sdram_cmd_o.cmd == RSQ_CMD_PRE && sdram_cke_o == 4'hf)
    else $error("no precharge after reset");
  // Self-refresh entry drops all enables within the array walk
  sr_entry_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (mem_st == RSQ_ST_RUN && self_refresh) |=> ##4 sdram_cke_o == 4'h0)
    else $error("clock enables not dropped");
  // Enables stay low while held; the last entry command still stands on the first hold cycle
  sr_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (mem_st == RSQ_ST_SRHOLD && self_refresh) |=> sdram_cke_o == 4'h0 && sdram_cmd_o.cmd == RSQ_CMD_NOP)
    else $error("activity during self-refresh");
  // Exit raises enables and no refresh in the next cycle
  sr_exit_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (mem_st == RSQ_ST_SRHOLD && !self_refresh) |=> sdram_cke_o == 4'hf ##1 sdram_cmd_o.cmd != RSQ_CMD_REF)
    else $error("bad self-refresh exit");
  // Strap reflects the pins at release
  strap_catch_a: assert property (@(posedge clk_i)
    $fell(rst_i) |=> strap == $past(cfg_strap_i)) else $error("strap not captured");
endmodule

/* tb/rsq_far_model.sv */
// SDRAM array and PCI device side model watching the sequencer pins
`timescale 1ns/1ns
module rsq_far_model import rsq_pkg::*; (
  // Clock and reset
  input  wire logic           clk_i,
  input  wire logic           rst_i,
  // Pins seen by arrays and PCI devices
  input  wire rsq_sdram_cmd_s sdram_cmd_i,
  input  wire logic           wide_req_n_i,
  input  wire logic           wide_req_oe_i,
  // What the far side has seen
  output logic [3:0]          pre_seen_o,
  output logic [3:0]          self_seen_o,
  output logic                wide_line_o
);
  // Each array remembers precharge and self-refresh since the last reset
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pre_seen_o  <= 4'h0;
      self_seen_o <= 4'h0;
    end else begin
      if (sdram_cmd_i.cmd == RSQ_CMD_PRE)
        pre_seen_o[sdram_cmd_i.array] <= 1'b1;
      if (sdram_cmd_i.cmd == RSQ_CMD_SELF)
        self_seen_o[sdram_cmd_i.array] <= 1'b1;
    end
  end

  // Weak pull-up wins once the driver lets go, so a release reads high
  assign wide_line_o = wide_req_oe_i ? wide_req_n_i : 1'b1;
endmodule

/* tb/rsq_top_tb.sv */
// Self-checking bench for the reset and power sequencer
`timescale 1ns/1ns
`include "rsq_consts.svh"
module rsq_top_tb import rsq_pkg::*; ();
  // Bench driven inputs
  logic           clk_i       = 1'b0;
  logic           rst_i       = 1'b1;
  logic           cyc_i       = 1'b0;
  logic           stb_i       = 1'b0;
  logic           we_i        = 1'b0;
  logic [7:0]     adr_i       = 8'h00;
  logic [3:0]     sel_i       = 4'h0;
  logic [31:0]    dat_i       = 32'h0;
  logic           req_cpu_i   = 1'b0;
  logic [7:0]     cfg_strap_i = 8'h5a;
  // Design outputs and model observations
  logic [31:0]    dat_o;
  logic           ack_o, pci_gnt_oe_o, pullup_en_o, pci_clk_o, pci_rst_n_o;
  logic           wide_req_n_o, wide_req_oe_o, wide_line;
  logic [1:0]     probe_en_o;
  logic [3:0]     sdram_cke_o, pre_seen, self_seen;
  rsq_sdram_cmd_s sdram_cmd_o;
  int             n_errors    = 0;
  int             checks_done = 0;

  rsq_top rsq_top_i (
    .clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i, .dat_o, .ack_o,
    .req_cpu_i, .cfg_strap_i, .probe_en_o, .pci_gnt_oe_o, .pullup_en_o, .pci_clk_o,
    .pci_rst_n_o, .wide_req_n_o, .wide_req_oe_o, .sdram_cmd_o, .sdram_cke_o
  );

  rsq_far_model rsq_far_model_i (
    .clk_i, .rst_i, .sdram_cmd_i(sdram_cmd_o), .wide_req_n_i(wide_req_n_o),
    .wide_req_oe_i(wide_req_oe_o), .pre_seen_o(pre_seen), .self_seen_o(self_seen),
    .wide_line_o(wide_line)
  );

  // 50 MHz system clock
  always #10 clk_i = ~clk_i;

  // Verdict, reached from the main sequence or a stalled wait
  task automatic complete_run();
    $display("errors %0d checks %0d", n_errors, checks_done);
    if (n_errors == 0 && checks_done > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic stall();
    n_errors++;
    $display("wrong value at %0t: wait ran out", $time);
    complete_run();
  endtask

  // Settled sampling just after an edge
  task automatic tick(input int k);
    repeat (k) @(posedge clk_i);
    #1;
  endtask

  // Classic single cycle; held until ack is sampled high
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    int n;
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i  <= w;
    adr_i <= a;
    dat_i <= d;
    sel_i <= 4'hf;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_o !== 1'b1 && n < 16);
    if (ack_o !== 1'b1) stall();
    q = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb(1'b1, a, d, q);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    wb(1'b0, a, 32'h0, q);
    chk(q, exp);
  endtask

  // Condition selector for bounded waits
  function automatic logic pick(input int s);
    case (s)
      0: return pci_rst_n_o;
      1: return wide_req_n_o;
      2: return ~wide_req_oe_o;
      default: return sdram_cmd_o.cmd == RSQ_CMD_REF;
    endcase
  endfunction

  task automatic wait_on(input int s, output int n);
    n = 0;
    do begin
      tick(1);
      n++;
    end while (pick(s) !== 1'b1 && n < 200);
    if (pick(s) !== 1'b1) stall();
  endtask

  // Reset for three edges, then follow the PCI release sequence
  // Called at a rising edge; reset is raised and dropped only on edges
  task automatic do_reset();
    int n;
    rst_i <= 1'b1;
    tick(2);
    chk({pci_rst_n_o, wide_req_n_o, wide_req_oe_o, pullup_en_o}, 32'h3);
    chk({probe_en_o, pci_gnt_oe_o, sdram_cke_o}, 32'hf);
    chk(sdram_cmd_o, 32'h0);
    @(posedge clk_i);
    rst_i <= 1'b0;
    wait_on(0, n);
    chk({pci_clk_o, wide_line}, 32'h2);
    wait_on(1, n);
    chk({n[7:0], wide_req_oe_o}, 32'h9);
    wait_on(2, n);
    chk({n[7:0], wide_line}, 32'h9);
  endtask

  // Main sequence
  initial begin
    int n;
    logic [7:0] ofs [8];
    ofs = '{`RSQ_TTR_OFS, `RSQ_TDR_OFS, `RSQ_STR_OFS, `RSQ_CSC_OFS,
            `RSQ_AAR0_OFS, 8'h20, 8'h24, 8'h28};
    do_reset();
    chk(pre_seen, 32'hf);
    rd(`RSQ_STRAP_OFS, 32'h5a);
    cfg_strap_i <= 8'h03;
    wr(`RSQ_STRAP_OFS, 32'h0);
    rd(`RSQ_STRAP_OFS, 32'h5a);
    wr(8'h38, 32'hffff_ffff);
    rd(8'h38, 32'h0);
    // Arbitration: second CPU wins, first CPU loses
    req_cpu_i <= 1'b1;
    rd(`RSQ_MISC_OFS, 32'h1);
    wr(`RSQ_MISC_OFS, 32'h220);
    rd(`RSQ_MISC_OFS, 32'h221);
    req_cpu_i <= 1'b0;
    wr(`RSQ_MISC_OFS, 32'h110);
    rd(`RSQ_MISC_OFS, 32'h230);
    wr(`RSQ_MISC_OFS, 32'h1000);
    rd(`RSQ_MISC_OFS, 32'h0);
    // Slow bus timing first, then system timing and config with gaps
    for (int i = 0; i < 8; i++) begin
      rd(ofs[i], 32'h0);
      wr(ofs[i], 32'h5a5a_0000 + 32'(ofs[i]));
      if (i == 2 || i == 3) tick(20);
    end
    for (int i = 0; i < 8; i++) rd(ofs[i], 32'h5a5a_0000 + 32'(ofs[i]));
    // Probes and arbiter stay off until enabled
    rd(`RSQ_PROBE_OFS, 32'h0);
    chk({probe_en_o, pci_gnt_oe_o}, 32'h0);
    wr(`RSQ_PROBE_OFS, 32'h3);
    wr(`RSQ_PCICTL_OFS, 32'h1);
    tick(1);
    chk({probe_en_o, pci_gnt_oe_o, pullup_en_o}, 32'hf);
    // Self-refresh entry after the write-drain wait
    tick(5000);
    wr(`RSQ_PWR_OFS, 32'h1);
    tick(6);
    chk({self_seen, sdram_cke_o}, 32'hf0);
    wr(`RSQ_MTR_OFS, 32'h1);
    rd(`RSQ_MTR_OFS, 32'h1);
    chk(sdram_cke_o, 32'h0);
    // Exit: clock enables back, refresh one interval later
    wr(`RSQ_PWR_OFS, 32'h0);
    tick(1);
    chk(sdram_cke_o, 32'hf);
    wait_on(3, n);
    chk(n, 32'd17);
    // Second reset in mid-run clears probes, arbiter and misc bits
    @(posedge clk_i);
    req_cpu_i <= 1'b1;
    do_reset();
    chk({pre_seen, sdram_cke_o}, 32'hff);
    rd(`RSQ_MISC_OFS, 32'h1);
    complete_run();
  end
endmodule
